// ==== logic/sdb4_port.v ====
// ddr burst-of-four separate-io sram port, pin-level behaviour
`timescale 1ns/1ps
`include "sdb4_map.vh"
module sdb4_port
#(
  parameter AW = 8,
  parameter WIDE = 1,
  parameter LOCK_CYCLES = `SDB4_LOCK_CYCLES
)
(
  // system clock and reset
  input wire clock,
  input wire nrst,
  // input clock pair from the controller
  input wire clk_in_p,
  input wire clk_in_n,
  // commands and address
  input wire read_sel_n,
  input wire write_sel_n,
  input wire dll_on,
  input wire [AW-1:0] address_in,
  // write data and masks
  input wire [35:0] write_data,
  input wire [3:0] byte_write_mask_n,
  // read side
  output reg [35:0] read_data,
  output reg read_data_oe,
  output reg read_valid,
  output reg echo_strobe_p,
  output reg echo_strobe_n,
  output reg dll_locked
);
  localparam BEAT_AW = AW + 2;
  localparam NB = WIDE ? 4 : 2;
  localparam DW = WIDE ? 36 : 18;
  localparam BW = DW / NB;
  wire kp_s, kn_s, rd_s, wr_s, dll_s;
  wire [AW-1:0] addr_s;
  wire [35:0] wd_s;
  wire [3:0] bm_s;
  wire [DW-1:0] mem_q;
  reg kp_q, kn_q;
  reg [11:0] lock_q;
  reg [AW-1:0] wa_q, wb1_q, wb2_q, ra_q;
  reg wpend_q, wb1_v_q, wb2_v_q;
  reg [2:0] wbeat_q;
  reg [AW-1:0] wcmd_q;
  reg [DW*4-1:0] wbuf_d, wbuf_q, b1_q, b2_q;
  reg [NB*4-1:0] wbe_d, wbe_q, b1_be_q, b2_be_q, rhit_be_q;
  reg wfirst;
  reg [1:0] widx;
  reg [2:0] rlat_q;
  reg [2:0] rbeat_q;
  reg rpend_q;
  reg rhit_q;
  reg [DW*4-1:0] rhit_dat_q;
  reg mem_we;
  reg [BEAT_AW-1:0] mem_wa, mem_ra;
  reg [DW-1:0] mem_wd;
  reg [NB-1:0] mem_be;
  wire rise_p = kp_s && !kp_q;
  wire rise_n = kn_s && !kn_q;
  wire [DW-1:0] rd_word;
  genvar g;

  // ****************************************
  // input synchronisers
  // ****************************************
  generate
    for (g = 0; g < 36 + 4 + AW + 5; g = g + 1)
    begin : syn
      wire i_bit;
      wire o_bit;
      if (g < 36)
      begin : d
        assign i_bit = write_data[g];
        assign wd_s[g] = o_bit;
      end
      else if (g < 40)
      begin : m
        assign i_bit = byte_write_mask_n[g-36];
        assign bm_s[g-36] = o_bit;
      end
      else if (g < 40 + AW)
      begin : a
        assign i_bit = address_in[g-40];
        assign addr_s[g-40] = o_bit;
      end
      else
      begin : c
        assign i_bit = (g == 40+AW) ? clk_in_p : (g == 41+AW) ? clk_in_n :
                       (g == 42+AW) ? read_sel_n :
                       (g == 43+AW) ? write_sel_n : dll_on;
      end
      sdb4_sync u_s (.clock(clock), .nrst(nrst), .din(i_bit), .dout(o_bit));
    end
  endgenerate
  assign kp_s = syn[40+AW].o_bit;
  assign kn_s = syn[41+AW].o_bit;
  assign rd_s = syn[42+AW].o_bit;
  assign wr_s = syn[43+AW].o_bit;
  assign dll_s = syn[44+AW].o_bit;

  // ****************************************
  // array
  // ****************************************
  sdb4_mem #(.AW(BEAT_AW), .DW(DW), .NB(NB)) u_mem
  (
    .clock(clock),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .wr_be(mem_be),
    .rd_addr(mem_ra),
    .rd_data(mem_q)
  );

  // ****************************************
  // edge detection and dll lock
  // ****************************************
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      kp_q <= 1'b0;
      kn_q <= 1'b0;
      lock_q <= 12'h000;
      dll_locked <= 1'b0;
    end
    else
    begin
      kp_q <= kp_s;
      kn_q <= kn_s;
      if (!dll_s)
      begin
        lock_q <= 12'h000;
        dll_locked <= 1'b0;
      end
      else if (rise_p && !dll_locked)
      begin
        lock_q <= lock_q + 12'h001;
        if (lock_q == LOCK_CYCLES - 1)
          dll_locked <= 1'b1;
      end
    end
  end

  // ****************************************
  // write path: command, beats, two-deep buffer
  // ****************************************
  always @*
  begin
    wbuf_d = wbuf_q;
    wbe_d = wbe_q;
    wfirst = wpend_q && rise_p && (wbeat_q == `SDB4_BEATS);
    widx = wfirst ? 2'd0 : wbeat_q[1:0];
    wbuf_d[widx*DW +: DW] = wd_s[DW-1:0];
    wbe_d[widx*NB +: NB] = ~bm_s[NB-1:0];
  end

  always @(posedge clock)
  begin
    if (!nrst)
    begin
      wpend_q <= 1'b0;
      wbeat_q <= `SDB4_BEATS;
      wcmd_q <= {AW{1'b0}};
      wa_q <= {AW{1'b0}};
      wb1_q <= {AW{1'b0}};
      wb2_q <= {AW{1'b0}};
      wb1_v_q <= 1'b0;
      wb2_v_q <= 1'b0;
      wbuf_q <= {DW*4{1'b0}};
      b1_q <= {DW*4{1'b0}};
      b2_q <= {DW*4{1'b0}};
      wbe_q <= {NB*4{1'b0}};
      b1_be_q <= {NB*4{1'b0}};
      b2_be_q <= {NB*4{1'b0}};
    end
    else
    begin
      // write command on true rise only; both high is a no-op
      if (rise_p && !wr_s)
      begin
        // kept apart from wa_q so a write two cycles on keeps the old burst
        wcmd_q <= addr_s;
        wpend_q <= 1'b1;
      end
      // first beat on next true rise, then every clock rise
      if (wfirst)
      begin
        wpend_q <= 1'b0;
        wbeat_q <= 3'd1;
        wa_q <= wcmd_q;
        wbuf_q <= wbuf_d;
        wbe_q <= wbe_d;
      end
      else if (wbeat_q < `SDB4_BEATS && (rise_p || rise_n))
      begin
        wbuf_q <= wbuf_d;
        wbe_q <= wbe_d;
        wbeat_q <= wbeat_q + 3'd1;
        if (wbeat_q[1:0] == `SDB4_LAST_BEAT)
        begin
          b2_q <= b1_q;
          b1_q <= wbuf_d;
          b2_be_q <= b1_be_q;
          b1_be_q <= wbe_d;
          wb2_q <= wb1_q;
          wb1_q <= wa_q;
          wb2_v_q <= wb1_v_q;
          wb1_v_q <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // array write and read address muxing
  // ****************************************
  always @*
  begin
    mem_we = wfirst || ((wbeat_q < `SDB4_BEATS) && (rise_p || rise_n));
    mem_wa = {(wfirst ? wcmd_q : wa_q), widx};
    mem_wd = wd_s[DW-1:0];
    mem_be = ~bm_s[NB-1:0];
    mem_ra = {ra_q, rbeat_q[1:0]};
  end

  // a buffer hit only overrides the lanes that burst really wrote
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : hit
      assign rd_word[g*BW +: BW] =
        (rhit_q && rhit_be_q[rbeat_q[1:0]*NB + g]) ?
        rhit_dat_q[rbeat_q[1:0]*DW + g*BW +: BW] : mem_q[g*BW +: BW];
    end
  endgenerate

  // ****************************************
  // read path: latency, beats, echo clocks
  // ****************************************
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      rpend_q <= 1'b0;
      rlat_q <= 3'd0;
      rbeat_q <= `SDB4_BEATS;
      ra_q <= {AW{1'b0}};
      rhit_q <= 1'b0;
      rhit_dat_q <= {DW*4{1'b0}};
      rhit_be_q <= {NB*4{1'b0}};
      read_data <= 36'h000000000;
      read_data_oe <= 1'b0;
      read_valid <= 1'b0;
      echo_strobe_p <= 1'b0;
      echo_strobe_n <= 1'b1;
    end
    else
    begin
      // echo pair follows the input clock edges, free running
      if (rise_p || rise_n)
      begin
        echo_strobe_p <= rise_p;
        echo_strobe_n <= rise_n;
      end
      if (rise_p && !rd_s)
      begin
        ra_q <= addr_s;
        rpend_q <= 1'b1;
        rlat_q <= dll_s ? `SDB4_LAT_DLL_ON : `SDB4_LAT_DLL_OFF;
        rbeat_q <= 3'd0;
        if (wb1_v_q && addr_s == wb1_q)
        begin
          rhit_q <= 1'b1;
          rhit_dat_q <= b1_q;
          rhit_be_q <= b1_be_q;
        end
        else if (wb2_v_q && addr_s == wb2_q)
        begin
          rhit_q <= 1'b1;
          rhit_dat_q <= b2_q;
          rhit_be_q <= b2_be_q;
        end
        else
          rhit_q <= 1'b0;
      end
      else if ((rise_p || rise_n) && rpend_q)
      begin
        if (rlat_q > 3'd1)
          rlat_q <= rlat_q - 3'd1;
        else
        begin
          // beat launched on the same edge as the echo clock
          read_data <= 36'h000000000;
          read_data[DW-1:0] <= rd_word;
          read_data_oe <= 1'b1;
          read_valid <= 1'b1;
          rbeat_q <= rbeat_q + 3'd1;
          if (rbeat_q[1:0] == `SDB4_LAST_BEAT)
            rpend_q <= 1'b0;
        end
      end
      else if ((rise_p || rise_n) && !rpend_q)
      begin
        read_data_oe <= 1'b0;
        read_valid <= 1'b0;
      end
    end
  end
endmodule // sdb4_port

// ==== logic/sdb4_map.vh ====
// constants for the ddr burst-of-four sram port
`ifndef SDB4_MAP_VH
`define SDB4_MAP_VH
// dll lock time in input clock cycles, counted on true-clock rises
`define SDB4_LOCK_CYCLES 2048
// read latency in half cycles, counted from the command rise
`define SDB4_LAT_DLL_ON 3'd5
`define SDB4_LAT_DLL_OFF 3'd2
// burst length in beats
`define SDB4_BEATS 3'd4
// last beat index of a burst
`define SDB4_LAST_BEAT 2'd3
// write delay in half cycles, from the command rise to the first data beat on the next true-clock rise
`define SDB4_WR_DELAY 2'd2
`endif

// ==== logic/sdb4_sync.v ====
// two-flop synchroniser for one level
`timescale 1ns/1ps
module sdb4_sync
(
  // clock and reset
  input wire clock,
  input wire nrst,
  // asynchronous level in, synchronised level out
  input wire din,
  output reg dout
);
  reg meta_q;

  // ****************************************
  // synchroniser
  // ****************************************
  // first flop feeds only the second
  always @(posedge clock)
  begin
    if (!nrst)
    begin
      meta_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // sdb4_sync

// ==== logic/sdb4_mem.v ====
// word store for the sram array, registered read data
`timescale 1ns/1ps
module sdb4_mem
#(
  parameter AW = 8,
  parameter DW = 36,
  parameter NB = 4
)
(
  // clock
  input wire clock,
  // write port with byte enables
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [NB-1:0] wr_be,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);
  localparam BW = DW / NB;
  reg [DW-1:0] mem [0:(1<<AW)-1];
  genvar g;

  // ****************************************
  // byte-lane writes
  // ****************************************
  generate
    for (g = 0; g < NB; g = g + 1)
    begin : lane
      always @(posedge clock)
      begin
        if (wr_en && wr_be[g])
          mem[wr_addr][g*BW +: BW] <= wr_data[g*BW +: BW];
      end
    end
  endgenerate

  // registered read
  always @(posedge clock)
  begin
    rd_data <= mem[rd_addr];
  end
endmodule // sdb4_mem

// ==== sim/sdb4_host.sv ====
// far-side controller model: input clock pair and phase count
`timescale 1ns/1ps
module sdb4_host
(
  // system clock
  input wire clock,
  // input clock pair and position within its period
  output reg clk_in_p,
  output reg clk_in_n,
  output reg [2:0] phase
);
  // free-running pair from time zero
  initial
  begin
    phase = 3'h0;
    clk_in_p = 1'b1;
    clk_in_n = 1'b0;
  end
  // eight clocks a period, complement half a period later
  always @(posedge clock)
  begin
    phase <= phase + 3'h1;
    clk_in_p <= (phase == 3'h7) || (phase < 3'h3);
    clk_in_n <= (phase >= 3'h3) && (phase != 3'h7);
  end
endmodule // sdb4_host

// ==== sim/sdb4_port_checker.sv ====
// assertions on the sram port outputs
`timescale 1ns/1ps
module sdb4_port_checker
#(
  parameter LOCK_CYCLES = 2048
)
(
  // clock and reset
  input wire clock,
  input wire nrst,
  // dll control
  input wire dll_on,
  // read side
  input wire [35:0] read_data,
  input wire read_data_oe,
  input wire read_valid,
  input wire echo_strobe_p,
  input wire echo_strobe_n,
  input wire dll_locked
);
  // fewest clocks to lock: one pin period is eight clocks here
  localparam LOCK_MIN = (LOCK_CYCLES - 1) * 8;
  reg [15:0] on_q;
  reg [3:0] run_q;
  // clocks with dll on; clocks since the echo strobe last moved
  always @(posedge clock)
  begin
    if (!nrst || !dll_on)
      on_q <= 16'h0000;
    else if (on_q != 16'hffff)
      on_q <= on_q + 16'h0001;
    if (!nrst || $changed(echo_strobe_p))
      run_q <= 4'h0;
    else if (run_q != 4'hf)
      run_q <= run_q + 4'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  idle_valid_a: assert property (!read_data_oe |-> !read_valid)
    else $error("valid without data");
  echo_run_a: assert property (run_q < 4'hc)
    else $error("echo strobe stopped");
  valid_rise_a: assert property ($rose(read_valid) |->
    $rose(echo_strobe_p) || $rose(echo_strobe_n))
    else $error("valid rise off echo edge");
  valid_fall_a: assert property ($fell(read_valid) |->
    $changed(echo_strobe_p) || $changed(echo_strobe_n))
    else $error("valid fall off echo edge");
  data_edge_a: assert property (read_data_oe && $past(read_data_oe)
    && $changed(read_data) |-> $changed(echo_strobe_p)
    || $changed(echo_strobe_n))
    else $error("data moved off echo edge");
  burst_len_a: assert property ($rose(read_valid) |->
    read_valid [*8] ##1 read_valid [*8] ##1 !read_valid)
    else $error("burst not four beats long");
  lock_clear_a: assert property (!dll_on [*6] |-> !dll_locked)
    else $error("lock kept while bypassed");
  lock_time_a: assert property ($rose(dll_locked) |-> on_q >= LOCK_MIN)
    else $error("lock too early");
  cover property ($rose(read_valid) && dll_on);
  cover property ($rose(read_valid) && !dll_on);
  cover property ($rose(dll_locked));
endmodule // sdb4_port_checker

// ==== sim/sdb4_port_test.sv ====
// self-checking bench for the ddr burst-of-four sram port
`timescale 1ns/1ps
module sdb4_port_test;
  reg clock;
  reg nrst;
  reg read_sel_n;
  reg write_sel_n;
  reg dll_on;
  reg [7:0] address_in;
  reg [35:0] write_data;
  reg [3:0] byte_write_mask_n;
  wire clk_in_p;
  wire clk_in_n;
  wire [2:0] phase;
  wire [35:0] read_data;
  wire read_data_oe;
  wire read_valid;
  wire echo_strobe_p;
  wire echo_strobe_n;
  wire dll_locked;
  reg [35:0] exp_q [0:1023];
  integer fails;
  integer comparisons;
  integer cycles;
  sdb4_host host_u (.clock(clock), .clk_in_p(clk_in_p),
    .clk_in_n(clk_in_n), .phase(phase));
  sdb4_port #(.AW(8), .WIDE(1), .LOCK_CYCLES(8)) dut_u (.clock(clock),
    .nrst(nrst), .clk_in_p(clk_in_p), .clk_in_n(clk_in_n),
    .read_sel_n(read_sel_n), .write_sel_n(write_sel_n), .dll_on(dll_on),
    .address_in(address_in), .write_data(write_data),
    .byte_write_mask_n(byte_write_mask_n), .read_data(read_data),
    .read_data_oe(read_data_oe), .read_valid(read_valid),
    .echo_strobe_p(echo_strobe_p), .echo_strobe_n(echo_strobe_n),
    .dll_locked(dll_locked));
  // ****************************************
  // helpers and scenarios
  // ****************************************
  always #25 clock = ~clock;
  task test_done;
  begin
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task cmp(input string nm, input [35:0] e, input [35:0] s);
  begin
    comparisons = comparisons + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // wait for the edge that ends phase k
  task at_ph(input [2:0] k);
  begin
    @(posedge clock);
    while (phase !== k)
      @(posedge clock);
  end
  endtask
  // command, then four beats p,n,p,n starting one cycle later
  task wr(input [7:0] a, input [35:0] b, input [15:0] m, input en);
    integer i;
    integer j;
    reg [35:0] d;
  begin
    at_ph(3'h5);
    write_sel_n <= ~en;
    address_in <= a;
    at_ph(3'h1);
    write_sel_n <= 1'b1;
    address_in <= ~a;
    for (i = 0; i < 4; i = i + 1)
    begin
      d = b ^ {9{i[3:0]}};
      at_ph(i[0] ? 3'h1 : 3'h5);
      write_data <= d;
      byte_write_mask_n <= m[4*i+:4];
      for (j = 0; j < 4; j = j + 1)
        if (en && !m[4*i+j])
          exp_q[{a, i[1:0]}][9*j+:9] = d[9*j+:9];
    end
    at_ph(3'h5);
    write_data <= ~write_data;
    byte_write_mask_n <= 4'hf;
  end
  endtask
  // read, count echo n rises up to the first beat, check all beats
  task rd(input [7:0] a, input integer lat);
    integer i;
    integer n;
    reg pn;
  begin
    at_ph(3'h5);
    read_sel_n <= 1'b0;
    address_in <= a;
    at_ph(3'h1);
    read_sel_n <= 1'b1;
    address_in <= ~a;
    n = 0;
    pn = echo_strobe_n;
    for (i = 0; i < 60 && read_valid !== 1'b1; i = i + 1)
    begin
      @(posedge clock);
      #1;
      n = n + (echo_strobe_n && !pn);
      pn = echo_strobe_n;
    end
    cmp("echo_n_rises", lat, n);
    for (i = 0; i < 4; i = i + 1)
    begin
      cmp("read_data", exp_q[{a, i[1:0]}], read_data);
      cmp("read_oe", 1, read_data_oe);
      repeat (4) @(posedge clock);
      #1;
    end
    cmp("read_valid", 0, read_valid);
  end
  endtask
  task t_lock;
    integer n;
  begin
    @(posedge clock);
    dll_on <= 1'b1;
    for (n = 0; n < 300 && dll_locked !== 1'b1; n = n + 1)
      @(posedge clock);
    cmp("lock_seen", 1, dll_locked);
    cmp("lock_late", 1, n >= 56);
    $display("test lock done");
  end
  endtask
  task t_rw;
  begin
    wr(8'h12, 36'h123456789, 16'h0000, 1'b1);
    wr(8'h12, 36'hfedcba987, 16'h8421, 1'b1);
    wr(8'h12, 36'h5a5a5a5a5, 16'h0000, 1'b0);
    rd(8'h12, 3);
    wr(8'h34, 36'h0f0f0f0f0, 16'h0000, 1'b1);
    wr(8'h56, 36'ha5a5a5a5a, 16'h0000, 1'b1);
    rd(8'h12, 3);
    rd(8'h34, 3);
    $display("test write read done");
  end
  endtask
  task t_off;
  begin
    @(posedge clock);
    dll_on <= 1'b0;
    repeat (16) @(posedge clock);
    cmp("lock_off", 0, dll_locked);
    rd(8'h56, 1);
    rd(8'h12, 1);
    $display("test bypass done");
  end
  endtask
  // cut a hang short
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      fails = fails + 1;
      test_done;
    end
  end
  // reset, then the scenarios in turn
  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    dll_on = 1'b0;
    address_in = 8'h00;
    write_data = 36'h000000000;
    byte_write_mask_n = 4'hf;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    #1;
    cmp("valid_rst", 0, read_valid);
    cmp("locked_rst", 0, dll_locked);
    $display("test reset done");
    repeat (4) @(posedge clock);
    t_lock;
    t_rw;
    t_off;
    test_done;
  end
endmodule // sdb4_port_test
bind sdb4_port sdb4_port_checker #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
  .clock(clock), .nrst(nrst), .dll_on(dll_on), .read_data(read_data),
  .read_data_oe(read_data_oe), .read_valid(read_valid),
  .echo_strobe_p(echo_strobe_p), .echo_strobe_n(echo_strobe_n),
  .dll_locked(dll_locked));
